// ===== logic/mcs_pkg.sv
// constants, commands and states of the measurement command sequencer
package mcs_pkg;

  // --------------------------------------------------------------
  // decoded commands from the command link front end
  // --------------------------------------------------------------
  typedef enum logic [3:0] {
    CMD_SINGLE_SENSOR_TEMP     = 4'h0,
    CMD_SINGLE_PRESSURE_PERIOD = 4'h1,
    CMD_SINGLE_TEMP_PERIOD     = 4'h2,
    CMD_HOLD_PRESSURE          = 4'h3,
    CMD_HOLD_PRESSURE_PERIOD   = 4'h4,
    CMD_HOLD_SENSOR_TEMP       = 4'h5,
    CMD_HOLD_TEMP_PERIOD       = 4'h6,
    CMD_DUMP_BUFFER            = 4'h7,
    CMD_DUMP_SEQUENTIAL        = 4'h8,
    CMD_CONTINUOUS_PRESSURE    = 4'h9,
    CMD_FAST_CONTINUOUS        = 4'hA,
    CMD_CONTINUOUS_COMBINED    = 4'hB,
    CMD_WRITE_ENABLE           = 4'hC,
    CMD_SET_INTERVAL           = 4'hD,
    CMD_READ_INTERVAL          = 4'hE,
    CMD_OTHER                  = 4'hF
  } mcs_cmd_e;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_TMEAS = 3'h1,
    ST_PMEAS = 3'h2,
    ST_CALC  = 3'h3,
    ST_HOLD  = 3'h4,
    ST_SEND  = 3'h5,
    ST_ECHO  = 3'h6
  } mcs_state_e;

  // reply formats handed to the framer
  typedef enum logic [1:0] {
    FMT_VALUE    = 2'h0,
    FMT_COMBINED = 2'h1,
    FMT_ECHO     = 2'h2,
    FMT_PARAM    = 2'h3
  } mcs_fmt_e;

  // measurement kinds and calculation operations
  localparam logic MEAS_TEMP_PERIOD  = 1'h0;
  localparam logic MEAS_PRESS_PERIOD = 1'h1;
  localparam logic CALC_SENSOR_TEMP  = 1'h0;
  localparam logic CALC_COMPENSATE   = 1'h1;

  localparam logic [3:0]  UNIT_BAR         = 4'h3;
  localparam logic [15:0] INTERVAL_RESET   = 16'h0000;
  localparam logic [15:0] INTERVAL_ONE     = 16'h0001;
  localparam logic [15:0] INTERVAL_ZERO    = 16'h0000;
  localparam logic        INTEG_SIMULT     = 1'h0;

endpackage

// ===== logic/mcs_sequencer.sv
// measurement command sequencer: measurement, hold, dump and stream control
`timescale 1ns/10ps
module mcs_sequencer #(
  parameter int DW = 32,
  parameter int AW = 8
) (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  cmd_valid,
  input  wire mcs_pkg::mcs_cmd_e     cmd_code,
  input  wire logic                  cmd_global,
  input  wire logic                  cmd_on_rs485,
  input  wire logic [AW-1:0]         cmd_addr,
  input  wire logic [15:0]           cmd_arg,
  input  wire logic [3:0]            pressure_unit_select,
  input  wire logic                  temperature_unit_select,
  input  wire logic                  integration_mode_select,
  input  wire logic                  meas_done,
  input  wire logic [DW-1:0]         meas_period,
  input  wire logic                  calc_done,
  input  wire logic [DW-1:0]         calc_result,
  input  wire logic                  reply_ready,
  output logic                       meas_req,
  output logic                       meas_kind,
  output logic                       meas_abort,
  output logic                       calc_req,
  output logic                       calc_op,
  output logic                       calc_temp_unit,
  output logic [DW-1:0]              calc_temp_period,
  output logic [DW-1:0]              calc_operand,
  output logic                       reply_valid,
  output mcs_pkg::mcs_fmt_e          reply_fmt,
  output logic [DW-1:0]              reply_value,
  output logic [AW-1:0]              reply_addr,
  output logic [15:0]                temp_remeasure_interval,
  output logic                       write_enabled,
  output logic                       busy
);

  initial begin
    if (DW < 16 || AW < 1) $error("mcs_sequencer: DW must be >= 16 and AW >= 1");
  end

  // --------------------------------------------------------------
  // state
  // --------------------------------------------------------------
  mcs_pkg::mcs_state_e state_r, state_nxt;
  mcs_pkg::mcs_cmd_e   mode_r;
  mcs_pkg::mcs_cmd_e   dump_cmd_r;
  logic [DW-1:0]       tper_r;
  logic [DW-1:0]       held_r;
  logic                held_valid_r;
  logic                dump_pend_r;
  logic [15:0]         pcount_r;
  logic [15:0]         interval_r;
  logic                wen_r;

  // --------------------------------------------------------------
  // command decode
  // --------------------------------------------------------------
  function automatic logic is_hold(input mcs_pkg::mcs_cmd_e c);
    is_hold = (c == mcs_pkg::CMD_HOLD_PRESSURE) || (c == mcs_pkg::CMD_HOLD_PRESSURE_PERIOD)
           || (c == mcs_pkg::CMD_HOLD_SENSOR_TEMP) || (c == mcs_pkg::CMD_HOLD_TEMP_PERIOD);
  endfunction

  function automatic logic is_stream(input mcs_pkg::mcs_cmd_e c);
    is_stream = (c == mcs_pkg::CMD_CONTINUOUS_PRESSURE) || (c == mcs_pkg::CMD_FAST_CONTINUOUS)
             || (c == mcs_pkg::CMD_CONTINUOUS_COMBINED);
  endfunction

  wire logic is_dump     = (cmd_code == mcs_pkg::CMD_DUMP_BUFFER)
                        || (cmd_code == mcs_pkg::CMD_DUMP_SEQUENTIAL);
  // a global sequential dump on the multidrop port is dropped entirely
  wire logic dump_ignore = (cmd_code == mcs_pkg::CMD_DUMP_SEQUENTIAL)
                        && cmd_global && cmd_on_rs485;
  wire logic comb_ignore = (cmd_code == mcs_pkg::CMD_CONTINUOUS_COMBINED)
                        && (pressure_unit_select != mcs_pkg::UNIT_BAR);
  wire logic cmd_take    = cmd_valid && !dump_ignore && !comb_ignore;
  wire logic hold_busy   = is_hold(mode_r) && (state_r inside {mcs_pkg::ST_TMEAS,
                           mcs_pkg::ST_PMEAS, mcs_pkg::ST_CALC});
  // dump while a held measurement runs keeps it running
  wire logic dump_defer  = cmd_take && is_dump && hold_busy;
  wire logic cmd_new     = cmd_take && !dump_defer;
  wire logic dump_now    = cmd_new && is_dump && held_valid_r;
  wire logic wr_ok       = cmd_new && (cmd_code == mcs_pkg::CMD_SET_INTERVAL) && wen_r
                        && (cmd_arg != mcs_pkg::INTERVAL_ZERO);
  wire logic starts_pres = (cmd_code == mcs_pkg::CMD_SINGLE_PRESSURE_PERIOD)
                        || (cmd_code == mcs_pkg::CMD_HOLD_PRESSURE_PERIOD);
  wire logic starts_meas = (cmd_code <= mcs_pkg::CMD_HOLD_TEMP_PERIOD) || is_stream(cmd_code);

  // fast mode temperature decision
  wire logic fast_mode   = (mode_r == mcs_pkg::CMD_FAST_CONTINUOUS);
  wire logic need_temp   = !fast_mode
                        || (integration_mode_select == mcs_pkg::INTEG_SIMULT)
                        || (interval_r == mcs_pkg::INTERVAL_ONE)
                        || ((interval_r > mcs_pkg::INTERVAL_ONE)
                            && (pcount_r >= interval_r));
  wire logic pres_only   = (mode_r == mcs_pkg::CMD_SINGLE_PRESSURE_PERIOD)
                        || (mode_r == mcs_pkg::CMD_HOLD_PRESSURE_PERIOD);
  wire logic temp_only   = (mode_r == mcs_pkg::CMD_SINGLE_TEMP_PERIOD)
                        || (mode_r == mcs_pkg::CMD_HOLD_TEMP_PERIOD);
  wire logic temp_conv   = (mode_r == mcs_pkg::CMD_SINGLE_SENSOR_TEMP)
                        || (mode_r == mcs_pkg::CMD_HOLD_SENSOR_TEMP);
  wire logic result_rdy  = ((state_r == mcs_pkg::ST_TMEAS) && meas_done && temp_only)
                        || ((state_r == mcs_pkg::ST_PMEAS) && meas_done && pres_only)
                        || ((state_r == mcs_pkg::ST_CALC) && calc_done);
  wire logic [DW-1:0] result = (state_r == mcs_pkg::ST_CALC) ? calc_result : meas_period;
  wire logic hold_done   = result_rdy && is_hold(mode_r);
  wire logic send_done   = reply_valid && reply_ready;
  // a dump landing in the very cycle the held result appears is sent at once
  wire logic dump_send   = hold_done && (dump_pend_r || dump_defer);

  // --------------------------------------------------------------
  // next state
  // --------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    if (cmd_new) begin
      // any accepted command cancels a stream or a held value
      if (dump_now) begin
        state_nxt = mcs_pkg::ST_SEND;
      end else if (cmd_code == mcs_pkg::CMD_READ_INTERVAL) begin
        state_nxt = mcs_pkg::ST_SEND;
      end else if (starts_meas) begin
        state_nxt = starts_pres ? mcs_pkg::ST_PMEAS : mcs_pkg::ST_TMEAS;
      end else begin
        state_nxt = mcs_pkg::ST_IDLE;
      end
    end else begin
      case (state_r)
        mcs_pkg::ST_TMEAS: begin
          if (meas_done) begin
            if (temp_only) begin
              state_nxt = is_hold(mode_r) ? mcs_pkg::ST_HOLD : mcs_pkg::ST_SEND;
            end else if (temp_conv) begin
              state_nxt = mcs_pkg::ST_CALC;
            end else begin
              state_nxt = mcs_pkg::ST_PMEAS;
            end
          end
        end
        mcs_pkg::ST_PMEAS: begin
          if (meas_done) begin
            if (pres_only) begin
              state_nxt = is_hold(mode_r) ? mcs_pkg::ST_HOLD : mcs_pkg::ST_SEND;
            end else begin
              state_nxt = mcs_pkg::ST_CALC;
            end
          end
        end
        mcs_pkg::ST_CALC: begin
          if (calc_done) begin
            state_nxt = is_hold(mode_r) ? mcs_pkg::ST_HOLD : mcs_pkg::ST_SEND;
          end
        end
        mcs_pkg::ST_SEND: begin
          if (send_done) begin
            if (dump_cmd_r == mcs_pkg::CMD_DUMP_SEQUENTIAL && mode_r == dump_cmd_r) begin
              state_nxt = mcs_pkg::ST_ECHO;
            end else if (is_stream(mode_r)) begin
              state_nxt = need_temp ? mcs_pkg::ST_TMEAS : mcs_pkg::ST_PMEAS;
            end else begin
              state_nxt = mcs_pkg::ST_IDLE;
            end
          end
        end
        mcs_pkg::ST_ECHO: begin
          if (send_done) begin
            state_nxt = mcs_pkg::ST_IDLE;
          end
        end
        mcs_pkg::ST_IDLE, mcs_pkg::ST_HOLD: begin
          state_nxt = state_r;
        end
        default: begin
          state_nxt = mcs_pkg::ST_IDLE;
        end
      endcase
      if (dump_send) begin
        state_nxt = mcs_pkg::ST_SEND;
      end
    end
  end

  wire logic enter_t  = (state_nxt == mcs_pkg::ST_TMEAS) && (cmd_new || state_r != mcs_pkg::ST_TMEAS);
  wire logic enter_p  = (state_nxt == mcs_pkg::ST_PMEAS) && (cmd_new || state_r != mcs_pkg::ST_PMEAS);
  wire logic enter_c  = (state_nxt == mcs_pkg::ST_CALC) && (state_r != mcs_pkg::ST_CALC);
  wire logic enter_sd = (state_nxt == mcs_pkg::ST_SEND) && (state_r != mcs_pkg::ST_SEND || cmd_new);
  // engines still working on a cancelled request must drop it
  wire logic abort    = cmd_new && (state_r inside {mcs_pkg::ST_TMEAS, mcs_pkg::ST_PMEAS,
                        mcs_pkg::ST_CALC});
  wire mcs_pkg::mcs_fmt_e fmt_nxt =
      (cmd_new && cmd_code == mcs_pkg::CMD_READ_INTERVAL) ? mcs_pkg::FMT_PARAM :
      (mode_r == mcs_pkg::CMD_CONTINUOUS_COMBINED)        ? mcs_pkg::FMT_COMBINED :
                                                            mcs_pkg::FMT_VALUE;

  // --------------------------------------------------------------
  // registers
  // --------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r      <= mcs_pkg::ST_IDLE;
      mode_r       <= mcs_pkg::CMD_OTHER;
      dump_cmd_r   <= mcs_pkg::CMD_OTHER;
      tper_r       <= '0;
      held_r       <= '0;
      held_valid_r <= 1'b0;
      dump_pend_r  <= 1'b0;
      pcount_r     <= '0;
      interval_r   <= mcs_pkg::INTERVAL_RESET;
      wen_r        <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (cmd_new) begin
        mode_r <= is_dump ? cmd_code : cmd_code;
        dump_cmd_r <= cmd_code;
      end else if (dump_defer) begin
        dump_cmd_r <= cmd_code;
      end
      // write enable lasts for exactly the next command
      if (cmd_new) begin
        wen_r <= (cmd_code == mcs_pkg::CMD_WRITE_ENABLE);
      end
      if (wr_ok) begin
        interval_r <= cmd_arg;
      end
      if (state_r == mcs_pkg::ST_TMEAS && meas_done) begin
        tper_r   <= meas_period;
        pcount_r <= '0;
      end else if (state_r == mcs_pkg::ST_PMEAS && meas_done && pcount_r != 16'hFFFF) begin
        pcount_r <= pcount_r + 16'h0001;
      end
      if (cmd_new) begin
        held_valid_r <= 1'b0;
        dump_pend_r  <= 1'b0;
      end else begin
        if (dump_defer) begin
          dump_pend_r <= 1'b1;
        end
        if (hold_done) begin
          held_r       <= result;
          held_valid_r <= 1'b1;
        end
      end
      if (dump_send) begin
        held_valid_r <= 1'b0;
        dump_pend_r  <= 1'b0;
        mode_r       <= dump_defer ? cmd_code : dump_cmd_r;
      end
    end
  end

  // --------------------------------------------------------------
  // request and reply outputs, all registered
  // --------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      meas_req         <= 1'b0;
      meas_kind        <= mcs_pkg::MEAS_TEMP_PERIOD;
      meas_abort       <= 1'b0;
      calc_req         <= 1'b0;
      calc_op          <= mcs_pkg::CALC_SENSOR_TEMP;
      calc_temp_unit   <= 1'b0;
      calc_temp_period <= '0;
      calc_operand     <= '0;
      reply_valid      <= 1'b0;
      reply_fmt        <= mcs_pkg::FMT_VALUE;
      reply_value      <= '0;
      reply_addr       <= '0;
    end else begin
      meas_req   <= enter_t || enter_p;
      meas_abort <= abort;
      calc_req   <= enter_c;
      if (enter_t || enter_p) begin
        meas_kind <= enter_p ? mcs_pkg::MEAS_PRESS_PERIOD : mcs_pkg::MEAS_TEMP_PERIOD;
      end
      if (enter_c) begin
        calc_op          <= temp_conv ? mcs_pkg::CALC_SENSOR_TEMP : mcs_pkg::CALC_COMPENSATE;
        calc_temp_unit   <= temperature_unit_select;
        calc_temp_period <= (state_r == mcs_pkg::ST_TMEAS) ? meas_period : tper_r;
        calc_operand     <= meas_period;
      end
      if (cmd_new) begin
        reply_addr <= cmd_addr;
      end
      if (state_nxt == mcs_pkg::ST_ECHO) begin
        reply_valid <= 1'b1;
        reply_fmt   <= mcs_pkg::FMT_ECHO;
      end else if (enter_sd) begin
        reply_valid <= 1'b1;
        reply_fmt   <= fmt_nxt;
        reply_value <= (cmd_new && cmd_code == mcs_pkg::CMD_READ_INTERVAL) ?
                       {{(DW-16){1'b0}}, interval_r} :
                       (dump_now ? held_r : (hold_done ? result : result));
      end else if (send_done || cmd_new) begin
        reply_valid <= 1'b0;
      end
    end
  end

  assign temp_remeasure_interval = interval_r;
  assign write_enabled           = wen_r;
  assign busy                    = (state_r != mcs_pkg::ST_IDLE);

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_hold_silent: assert property (is_hold(mode_r) && state_r == mcs_pkg::ST_HOLD
      |-> !reply_valid) else $error("reply while holding");
  chk_dump_empty: assert property (dump_now == 1'b0 && cmd_new && is_dump
      |=> !reply_valid) else $error("empty dump produced a reply");
  chk_deferred_dump: assert property (dump_pend_r && hold_done
      |=> reply_valid && reply_value == $past(result)) else $error("late dump lost");
  chk_rs485_ignore: assert property (cmd_valid && dump_ignore
      |=> $stable(state_r)) else $error("global dump on multidrop acted");
  chk_write_refused: assert property (cmd_new && cmd_code == mcs_pkg::CMD_SET_INTERVAL && !wen_r
      |=> $stable(interval_r)) else $error("unprotected write took effect");
  chk_stream_stop: assert property (cmd_new && !starts_meas && !is_dump
      && cmd_code != mcs_pkg::CMD_READ_INTERVAL
      |=> state_r == mcs_pkg::ST_IDLE [*2]) else $error("stream kept running");
  chk_unit_gate: assert property (cmd_valid && comb_ignore
      |=> !meas_req) else $error("combined stream started without bar unit");
  chk_fast_no_temp: assert property (fast_mode && interval_r == mcs_pkg::INTERVAL_ZERO
      && integration_mode_select != mcs_pkg::INTEG_SIMULT && send_done && !cmd_take
      |=> meas_req && meas_kind == mcs_pkg::MEAS_PRESS_PERIOD) else $error("fast temp resampled");
  chk_echo_follows: assert property (state_r == mcs_pkg::ST_SEND && send_done && !cmd_take
      && dump_cmd_r == mcs_pkg::CMD_DUMP_SEQUENTIAL && mode_r == dump_cmd_r
      |=> reply_valid && reply_fmt == mcs_pkg::FMT_ECHO) else $error("echo missing");
  chk_hold_press_seq: assert property (mode_r == mcs_pkg::CMD_HOLD_PRESSURE && state_r == mcs_pkg::ST_TMEAS
      && meas_done && !cmd_take |=> meas_req && meas_kind == mcs_pkg::MEAS_PRESS_PERIOD)
      else $error("held pressure skipped pressure period");

  cov_deferred_dump: cover property (dump_defer ##[1:200] reply_valid);
  cov_fast_loop:     cover property (fast_mode && send_done ##[1:100] send_done);
  cov_seq_echo:      cover property (reply_fmt == mcs_pkg::FMT_ECHO && reply_valid);

endmodule

// ===== bench/mcs_engine_model.sv
// measurement engine, calculation engine and reply framer stand-in
`timescale 1ns/10ps
module mcs_engine_model #(
  parameter logic [31:0] PPER = 32'h0000_1234,
  parameter logic [31:0] TPER = 32'h0000_0567
) (
  input  wire logic        clk,
  input  wire logic        meas_req,
  input  wire logic        meas_kind,
  input  wire logic        meas_abort,
  input  wire logic        calc_req,
  input  wire logic        calc_op,
  input  wire logic [31:0] calc_operand,
  output logic             meas_done,
  output logic [31:0]      meas_period,
  output logic             calc_done,
  output logic [31:0]      calc_result,
  output logic             reply_ready,
  output int               n_temp,
  output int               n_press
);
  int          m_cnt;
  int          c_cnt;
  logic        kind_r;
  logic [31:0] opnd_r;
  initial begin
    {meas_done, calc_done, reply_ready, m_cnt, c_cnt, n_temp, n_press} = '0;
  end
  // ---------------------------------------------------------------
  // engines: random latency; result buses churn outside done pulses
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    meas_done <= 1'b0;
    calc_done <= 1'b0;
    meas_period <= $urandom;
    calc_result <= $urandom;
    reply_ready <= ($urandom % 3) != 0;
    if (meas_req) begin
      kind_r <= meas_kind;
      m_cnt <= 1 + $urandom % 6;
      if (meas_kind) n_press <= n_press + 1;
      else n_temp <= n_temp + 1;
    end else if (meas_abort) m_cnt <= 0;
    else if (m_cnt == 1) begin
      meas_done <= 1'b1;
      meas_period <= kind_r ? PPER : TPER;
      m_cnt <= 0;
    end else if (m_cnt > 1) m_cnt <= m_cnt - 1;
    if (calc_req) begin
      opnd_r <= calc_operand + 32'h0000_0100 + {31'h0, calc_op};
      c_cnt <= 1 + $urandom % 4;
    end else if (meas_abort) c_cnt <= 0;
    else if (c_cnt == 1) begin
      calc_done <= 1'b1;
      calc_result <= opnd_r;
      c_cnt <= 0;
    end else if (c_cnt > 1) c_cnt <= c_cnt - 1;
  end
endmodule

// ===== bench/tb_mcs_sequencer.sv
// self-checking bench for the measurement command sequencer
`timescale 1ns/10ps
module tb_mcs_sequencer;
  localparam logic [31:0] PPER = 32'h0000_1234;
  localparam logic [31:0] TPER = 32'h0000_0567;
  localparam logic [31:0] COMP = PPER + 32'h0000_0101;
  logic              clk = 1'b0, rst = 1'b1, cmd_valid = 1'b0, g_r = 1'b0, r_r = 1'b0;
  logic [3:0]        unit_sel = 4'h3;
  logic              tu_sel = 1'b0, oi_sel = 1'b1;
  mcs_pkg::mcs_cmd_e cmd_code = mcs_pkg::CMD_OTHER;
  logic [7:0]        cmd_addr = 8'h00;
  logic [15:0]       cmd_arg = 16'h0000, ivl;
  logic              meas_done, meas_req, meas_kind, meas_abort, calc_done, calc_req, calc_op;
  logic              reply_ready, reply_valid, busy;
  logic [31:0]       meas_period, calc_result, calc_operand, reply_value;
  mcs_pkg::mcs_fmt_e reply_fmt;
  int                n_mismatch = 0, checked = 0, n_temp, n_press, t0, p0, i;
  logic [33:0]       exp_q[$];
  logic [33:0]       got;
  mcs_sequencer u_dut (.clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_global(g_r), .cmd_on_rs485(r_r), .cmd_addr(cmd_addr), .cmd_arg(cmd_arg),
    .pressure_unit_select(unit_sel), .temperature_unit_select(tu_sel),
    .integration_mode_select(oi_sel), .meas_done(meas_done), .meas_period(meas_period),
    .calc_done(calc_done), .calc_result(calc_result), .reply_ready(reply_ready),
    .meas_req(meas_req), .meas_kind(meas_kind), .meas_abort(meas_abort), .calc_req(calc_req),
    .calc_op(calc_op), .calc_temp_unit(), .calc_temp_period(), .calc_operand(calc_operand),
    .reply_valid(reply_valid), .reply_fmt(reply_fmt), .reply_value(reply_value),
    .reply_addr(), .temp_remeasure_interval(ivl), .write_enabled(), .busy(busy));
  mcs_engine_model #(.PPER(PPER), .TPER(TPER)) u_eng (.clk(clk), .meas_req(meas_req),
    .meas_kind(meas_kind), .meas_abort(meas_abort), .calc_req(calc_req), .calc_op(calc_op),
    .calc_operand(calc_operand), .meas_done(meas_done), .meas_period(meas_period),
    .calc_done(calc_done), .calc_result(calc_result), .reply_ready(reply_ready),
    .n_temp(n_temp), .n_press(n_press));
  initial forever #12.5 clk = ~clk;
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic fail(string m);
    n_mismatch++;
    $display("MISMATCH %0t %s", $time, m);
  endtask
  task automatic chk(logic ok, string m);
    checked++;
    if (ok !== 1'b1) fail(m);
  endtask
  task automatic push(mcs_pkg::mcs_fmt_e f, logic [31:0] v);
    exp_q.push_back({f, v});
  endtask
  task automatic send(mcs_pkg::mcs_cmd_e c, logic [15:0] a = 16'h0000, logic g = 1'b0,
                      logic r = 1'b0);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_code <= c;
    cmd_arg <= a;
    g_r <= g;
    r_r <= r;
    cmd_addr <= 8'($urandom);
    @(posedge clk);
    cmd_valid <= 1'b0;
  endtask
  // waits for every noted reply, then watches a quiet spell for strays
  task automatic drain(int settle);
    for (int k = 0; k < 3000 && exp_q.size() != 0; k++) @(negedge clk);
    if (exp_q.size() != 0) begin
      fail("reply timeout");
      print_verdict();
    end else repeat (settle) @(negedge clk);
  endtask
  // stop right after the k-th reply; the next sample, already started, is aborted before it can reply
  task automatic stream(mcs_pkg::mcs_cmd_e c, mcs_pkg::mcs_fmt_e f, int k, logic [15:0] e);
    repeat (k) push(f, COMP);
    send(c);
    drain(0);
    push(mcs_pkg::FMT_PARAM, {16'h0000, e});
    send(mcs_pkg::CMD_READ_INTERVAL);
    drain(40);
  endtask
  // ---------------------------------------------------------------
  // reply monitor: oldest note against each accepted reply
  // ---------------------------------------------------------------
  always @(posedge clk) if (reply_valid === 1'b1 && reply_ready === 1'b1) begin
    checked++;
    if (exp_q.size() == 0) fail("unexpected reply");
    else begin
      got = exp_q.pop_front();
      if (reply_fmt !== got[33:32] || (got[33:32] != 2'h2 && reply_value !== got[31:0]))
        fail("reply format or value differs");
    end
  end
  initial begin
    void'($urandom(32'h3278));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk(busy === 1'b0 && reply_valid === 1'b0 && ivl === 16'h0000, "reset state");
    push(mcs_pkg::FMT_VALUE, PPER);
    send(mcs_pkg::CMD_SINGLE_PRESSURE_PERIOD);
    drain(20);
    push(mcs_pkg::FMT_VALUE, TPER);
    send(mcs_pkg::CMD_SINGLE_TEMP_PERIOD);
    drain(20);
    push(mcs_pkg::FMT_VALUE, TPER + 32'h0000_0100);
    send(mcs_pkg::CMD_SINGLE_SENSOR_TEMP);
    drain(20);
    push(mcs_pkg::FMT_VALUE, COMP);
    send(mcs_pkg::CMD_HOLD_PRESSURE);
    send(mcs_pkg::CMD_DUMP_BUFFER);
    drain(40);
    send(mcs_pkg::CMD_DUMP_BUFFER);
    drain(40);
    send(mcs_pkg::CMD_HOLD_SENSOR_TEMP);
    drain(60);
    send(mcs_pkg::CMD_HOLD_TEMP_PERIOD);
    drain(60);
    push(mcs_pkg::FMT_VALUE, TPER);
    send(mcs_pkg::CMD_DUMP_BUFFER);
    drain(20);
    send(mcs_pkg::CMD_HOLD_SENSOR_TEMP);
    drain(60);
    push(mcs_pkg::FMT_VALUE, TPER + 32'h0000_0100);
    push(mcs_pkg::FMT_ECHO, 32'h0000_0000);
    send(mcs_pkg::CMD_DUMP_SEQUENTIAL);
    drain(20);
    send(mcs_pkg::CMD_HOLD_PRESSURE_PERIOD);
    drain(60);
    send(mcs_pkg::CMD_DUMP_SEQUENTIAL, 16'h0000, 1'b1, 1'b1);
    drain(40);
    push(mcs_pkg::FMT_VALUE, PPER);
    send(mcs_pkg::CMD_DUMP_BUFFER, 16'h0000, 1'b1, 1'b0);
    drain(20);
    unit_sel <= 4'h2;
    send(mcs_pkg::CMD_CONTINUOUS_COMBINED);
    drain(60);
    chk(busy === 1'b0, "combined stream ran without bar unit");
    unit_sel <= 4'h3;
    stream(mcs_pkg::CMD_CONTINUOUS_COMBINED, mcs_pkg::FMT_COMBINED, 2, 16'h0000);
    stream(mcs_pkg::CMD_CONTINUOUS_PRESSURE, mcs_pkg::FMT_VALUE, 3, 16'h0000);
    for (i = 0; i < 4; i++) begin
      oi_sel <= i != 3;
      if (i > 0) begin
        send(mcs_pkg::CMD_WRITE_ENABLE);
        send(mcs_pkg::CMD_SET_INTERVAL, (i == 3) ? 16'h0002 : 16'(i));
      end
      t0 = n_temp;
      p0 = n_press;
      stream(mcs_pkg::CMD_FAST_CONTINUOUS, mcs_pkg::FMT_VALUE, 4, (i == 3) ? 16'h0002 : 16'(i));
      chk((i == 0) ? (n_temp - t0 == 1) : (n_temp - t0 - 1 == (n_press - p0 - 1) /
          ((i == 3) ? 1 : i) || n_temp - t0 - 1 == (n_press - p0) / ((i == 3) ? 1 : i)),
          "temperature remeasure count");
    end
    send(mcs_pkg::CMD_WRITE_ENABLE);
    send(mcs_pkg::CMD_OTHER);
    send(mcs_pkg::CMD_SET_INTERVAL, 16'h0005);
    send(mcs_pkg::CMD_WRITE_ENABLE);
    send(mcs_pkg::CMD_SET_INTERVAL, 16'h0000);
    push(mcs_pkg::FMT_PARAM, 32'h0000_0002);
    send(mcs_pkg::CMD_READ_INTERVAL);
    drain(20);
    chk(ivl === 16'h0002, "interval changed by refused write");
    print_verdict();
  end
endmodule
